// [rtl/nmsc_host.sv]
// host controller: axi4-lite registers in, command strobes out
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "nmsc_params.svh"
module nmsc_host (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	nmsc_if.host link // pins toward the driver
);

	nmsc_pkg::nmsc_hst_t r_reg;
	nmsc_pkg::nmsc_hst_t r_next;
	logic do_wr;
	logic busy;
	logic [2:0] new23;

	// one address and one data slot each; both close while a response waits
	assign s_axi_awready = ~r_reg.aw_pend & ~r_reg.bvalid;
	assign s_axi_wready = ~r_reg.w_pend & ~r_reg.bvalid;
	assign s_axi_arready = ~r_reg.rvalid;
	assign busy = r_reg.state != nmsc_pkg::NMSC_HST_IDLE;

	always_comb begin
		r_next = r_reg;
		new23 = r_reg.wdata[`NMSC_B23_LSB +: 3];
		if (s_axi_awvalid && s_axi_awready) begin
			r_next.aw_pend = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			r_next.w_pend = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end

		// strobe sequencer; each phase outlasts the far end's pin filter
		unique case (r_reg.state)
			nmsc_pkg::NMSC_HST_IDLE: begin
			end
			nmsc_pkg::NMSC_HST_LOW: begin
				if (r_reg.cnt == 4'h0) begin
					r_next.wr_n = 1'b1; // rising edge latches the byte [RL1]
					r_next.cnt = `NMSC_STROBE_CYC - 4'h1;
					r_next.state = nmsc_pkg::NMSC_HST_HIGH;
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			nmsc_pkg::NMSC_HST_HIGH: begin
				if (r_reg.cnt != 4'h0) begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end else if (!r_reg.idx && r_reg.two) begin
					r_next.idx = 1'b1;
					r_next.dc = 1'b1; // parameter phase [RL2]
					r_next.data = r_reg.byte1;
					r_next.wr_n = 1'b0;
					r_next.cnt = `NMSC_STROBE_CYC - 4'h1;
					r_next.state = nmsc_pkg::NMSC_HST_LOW;
				end else begin
					r_next.state = nmsc_pkg::NMSC_HST_IDLE;
				end
			end
		endcase

		// register write once both halves are in; send and reset requests while busy are dropped
		do_wr = r_reg.aw_pend & r_reg.w_pend & ~r_reg.bvalid;
		if (do_wr) begin
			r_next.aw_pend = 1'b0;
			r_next.w_pend = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = `NMSC_RESP_OKAY;
			unique case (r_reg.awaddr)
				`NMSC_REG_CFG: begin
					if (r_reg.wstrb[0]) begin
						r_next.ext_en = r_reg.wdata[`NMSC_CFG_EXT_BIT]; // [RL6]
					end
				end
				`NMSC_REG_SEND, `NMSC_REG_SWRST: begin
					if (r_reg.wstrb[0] && !busy) begin
						if (!r_reg.ext_en) begin
							r_next.ext_err = 1'b1; // pin low: device would ignore a send [RL6]
						end else if (r_reg.awaddr == `NMSC_REG_SEND &&
							(new23 < `NMSC_B23_MIN || new23 > `NMSC_B23_MAX)) begin
							r_next.inh_err = 1'b1; // never put an inhibited code out [RL5]
						end else begin
							r_next.two = r_reg.awaddr == `NMSC_REG_SEND;
							r_next.byte0 = (r_reg.awaddr == `NMSC_REG_SEND) ?
								`NMSC_CMD_BOOST_NORMAL : `NMSC_CMD_SW_RESET; // [RL1]
							r_next.byte1 = {1'b1, new23, 1'b0, r_reg.wdata[2:0]}; // [RL2]
							r_next.idx = 1'b0;
							r_next.dc = 1'b0; // command phase [RL1]
							r_next.data = r_next.byte0;
							r_next.wr_n = 1'b0;
							r_next.cnt = `NMSC_STROBE_CYC - 4'h1;
							r_next.state = nmsc_pkg::NMSC_HST_LOW;
						end
					end
				end
				`NMSC_REG_STATUS: begin
					// write one to clear; errors are set only by send or reset writes, never in the same cycle
					if (r_reg.wstrb[0] && r_reg.wdata[`NMSC_ST_INH_BIT]) begin
						r_next.inh_err = 1'b0;
					end
					if (r_reg.wstrb[0] && r_reg.wdata[`NMSC_ST_EXT_BIT]) begin
						r_next.ext_err = 1'b0;
					end
				end
				default: begin
					r_next.bresp = `NMSC_RESP_SLVERR;
				end
			endcase
		end

		// read path answers one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp = `NMSC_RESP_OKAY;
			r_next.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				`NMSC_REG_CFG: r_next.rdata[`NMSC_CFG_EXT_BIT] = r_reg.ext_en;
				`NMSC_REG_SEND, `NMSC_REG_SWRST: begin
				end
				`NMSC_REG_STATUS: begin
					r_next.rdata[`NMSC_ST_BUSY_BIT] = busy;
					r_next.rdata[`NMSC_ST_INH_BIT] = r_reg.inh_err;
					r_next.rdata[`NMSC_ST_EXT_BIT] = r_reg.ext_err;
				end
				default: r_next.rresp = `NMSC_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= '0;
			r_reg.state <= nmsc_pkg::NMSC_HST_IDLE;
			r_reg.wr_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign link.write_strobe_n = r_reg.wr_n;
	assign link.read_strobe_n = 1'b1; // never reads [RL1]
	assign link.data_cmd_select = r_reg.dc;
	assign link.data_bus = {10'h000, r_reg.data}; // upper lines held low
	assign link.ext_cmd_enable_pin = r_reg.ext_en;

endmodule : nmsc_host

// [rtl/nmsc_params.svh]
// constants for the normal-mode step-up cycle command path
//
// Overview of operation
// RL1: command byte C2h, select low, read high
// RL2: parameter: bit7 one, cycle fields, bit3 zero
// RL3: low field circuits 1/5, high field 2/3
// RL4: 1/5 codes give 1/16 H up to 8 H
// RL5: 2/3 codes 001-100 only; others inhibited
// RL6: command honoured only with extension pin high
// RL7: accepted in every display and sleep state
// RL8: all resets restore 010 and 011
// RL9: extension pin low leaves fields unchanged
`ifndef NMSC_PARAMS_SVH
`define NMSC_PARAMS_SVH

// command codes and parameter layout
`define NMSC_CMD_BOOST_NORMAL 8'hc2
`define NMSC_CMD_SW_RESET 8'h01
`define NMSC_PARAM_RST 8'hb2
`define NMSC_PARAM_MARK_BIT 7
`define NMSC_PARAM_ZERO_BIT 3
`define NMSC_B23_LSB 4
`define NMSC_B15_LSB 0
`define NMSC_B15_RST 3'h2
`define NMSC_B23_RST 3'h3
`define NMSC_B23_MIN 3'h1
`define NMSC_B23_MAX 3'h4

// device pin vector layout
`define NMSC_PIN_W 12
`define NMSC_PIN_WR 8
`define NMSC_PIN_RD 9
`define NMSC_PIN_DC 10
`define NMSC_PIN_EXT 11
`define NMSC_PIN_IDLE 12'h300
`define NMSC_BUS_W 18

// host strobe phase length in aclk cycles, covers the three-stage pin filter
`define NMSC_STROBE_CYC 4'h4

// host register map (byte addresses)
`define NMSC_REG_CFG 8'h00
`define NMSC_REG_SEND 8'h04
`define NMSC_REG_SWRST 8'h08
`define NMSC_REG_STATUS 8'h0c
`define NMSC_CFG_EXT_BIT 0
`define NMSC_ST_BUSY_BIT 0
`define NMSC_ST_INH_BIT 1
`define NMSC_ST_EXT_BIT 2
`define NMSC_RESP_OKAY 2'h0
`define NMSC_RESP_SLVERR 2'h2

`endif

// [rtl/nmsc_pkg.sv]
// types shared by both ends of the step-up cycle command path
`include "nmsc_params.svh"
package nmsc_pkg;

	typedef enum logic [1:0] {
		NMSC_DEV_CMD = 2'b01,
		NMSC_DEV_PARAM = 2'b10
	} nmsc_dev_state_t;

	typedef enum logic [2:0] {
		NMSC_HST_IDLE = 3'b001,
		NMSC_HST_LOW = 3'b010,
		NMSC_HST_HIGH = 3'b100
	} nmsc_hst_state_t;

	typedef struct packed {
		logic [`NMSC_PIN_W-1:0] sync1;
		logic [`NMSC_PIN_W-1:0] sync2;
		logic [`NMSC_PIN_W-1:0] sync3;
		logic [`NMSC_PIN_W-1:0] lvl;
		nmsc_dev_state_t state;
		logic [2:0] b15;
		logic [2:0] b23;
		logic [7:0] b15_16ths;
		logic [7:0] b23_16ths;
		logic b23_inhibit;
		logic update;
		logic sw_reset;
	} nmsc_dev_t;

	typedef struct packed {
		nmsc_hst_state_t state;
		logic [3:0] cnt;
		logic idx;
		logic two;
		logic [7:0] byte0;
		logic [7:0] byte1;
		logic wr_n;
		logic dc;
		logic [7:0] data;
		logic ext_en;
		logic inh_err;
		logic ext_err;
		logic aw_pend;
		logic [7:0] awaddr;
		logic w_pend;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} nmsc_hst_t;

endpackage : nmsc_pkg

// [rtl/nmsc_if.sv]
// pin-level link between the host controller and the driver command logic
`timescale 1ns/1ps
`include "nmsc_params.svh"
interface nmsc_if;
	logic data_cmd_select;
	logic read_strobe_n;
	logic write_strobe_n;
	logic [`NMSC_BUS_W-1:0] data_bus;
	logic ext_cmd_enable_pin;

	modport host (
		output data_cmd_select,
		output read_strobe_n,
		output write_strobe_n,
		output data_bus,
		output ext_cmd_enable_pin
	);

	modport device (
		input data_cmd_select,
		input read_strobe_n,
		input write_strobe_n,
		input data_bus,
		input ext_cmd_enable_pin
	);
endinterface : nmsc_if

// [rtl/nmsc_device.sv]
// driver-side decoder for the normal-mode step-up cycle command
`timescale 1ns/1ps
`include "nmsc_params.svh"
module nmsc_device (
	input wire logic aclk, // system clock
	input wire logic aresetn, // power-on / hardware reset, active low
	nmsc_if.device link, // pins from the host
	output logic [2:0] booster15_cycle_sel, // cycle code, circuits 1 and 5
	output logic [2:0] booster23_cycle_sel, // cycle code, circuits 2 and 3
	output logic [7:0] booster15_cycle_16ths, // cycle in sixteenths of a line
	output logic [7:0] booster23_cycle_16ths, // cycle in sixteenths, zero if inhibited
	output logic booster23_inhibit, // stored 2/3 code is an inhibited one
	output logic cycle_update, // pulse: parameter stored
	output logic sw_reset_seen // pulse: software reset decoded
);

	// data path: pins, three-flop filter, strobe edge decode, field store.
	// a stored field shows about four clocks after the write strobe rises; a
	// strobe phase shorter than two clocks can be missed, so the host stretches
	// each phase. the command opens a one-byte parameter window, and any other
	// command byte closes it. both cycle fields restart from their defaults on
	// the reset input and on the software reset command; the decoded periods
	// follow the stored codes, and inhibited 2/3 codes are flagged but kept so
	// that a host fault stays visible instead of being masked.

	// circuits 1/5: every code is legal; periods in sixteenths of a line
	function automatic logic [7:0] cyc15(input logic [2:0] code);
		unique case (code)
			3'h0: cyc15 = 8'h01; // 1/16 H [RL4]
			3'h1: cyc15 = 8'h02; // 1/8 H
			3'h2: cyc15 = 8'h04; // 1/4 H
			3'h3: cyc15 = 8'h08; // 1/2 H
			3'h4: cyc15 = 8'h10; // 1 H
			3'h5: cyc15 = 8'h20; // 2 H
			3'h6: cyc15 = 8'h40; // 4 H
			3'h7: cyc15 = 8'h80; // 8 H
		endcase
	endfunction : cyc15

	// circuits 2/3: only 1/8 H to 1 H exist, the rest reads as zero
	function automatic logic [7:0] cyc23(input logic [2:0] code);
		unique case (code)
			3'h0: cyc23 = 8'h00; // inhibited [RL5]
			3'h1: cyc23 = 8'h02; // 1/8 H
			3'h2: cyc23 = 8'h04; // 1/4 H
			3'h3: cyc23 = 8'h08; // 1/2 H
			3'h4: cyc23 = 8'h10; // 1 H
			3'h5: cyc23 = 8'h00; // inhibited
			3'h6: cyc23 = 8'h00; // inhibited
			3'h7: cyc23 = 8'h00; // inhibited
		endcase
	endfunction : cyc23

	// flag for codes the host must never send
	function automatic logic inh23(input logic [2:0] code);
		unique case (code)
			3'h1, 3'h2, 3'h3, 3'h4: inh23 = 1'b0;
			3'h0, 3'h5, 3'h6, 3'h7: inh23 = 1'b1; // [RL5]
		endcase
	endfunction : inh23

	// reset image: pins idle with both strobes high so release gives no false edge
	localparam nmsc_pkg::nmsc_dev_t RST = '{
		sync1: `NMSC_PIN_IDLE,
		sync2: `NMSC_PIN_IDLE,
		sync3: `NMSC_PIN_IDLE,
		lvl: `NMSC_PIN_IDLE,
		state: nmsc_pkg::NMSC_DEV_CMD,
		b15: `NMSC_B15_RST,
		b23: `NMSC_B23_RST,
		b15_16ths: cyc15(`NMSC_B15_RST),
		b23_16ths: cyc23(`NMSC_B23_RST),
		b23_inhibit: 1'b0,
		update: 1'b0,
		sw_reset: 1'b0
	};

	nmsc_pkg::nmsc_dev_t r_reg;
	nmsc_pkg::nmsc_dev_t r_next;
	logic [`NMSC_PIN_W-1:0] pins;
	logic wr_rise;
	logic rd_idle;
	logic dc_sel;
	logic ext_on;
	logic [7:0] rx_byte;

	// filter vote and parameter fields, combinational only
	logic [`NMSC_PIN_W-1:0] lvl_vote;
	logic [2:0] par15;
	logic [2:0] par23;

	// gather pins; upper data lines are never looked at
	assign pins = {
		link.ext_cmd_enable_pin,
		link.data_cmd_select,
		link.read_strobe_n,
		link.write_strobe_n,
		link.data_bus[7:0] // [RL2]
	};

	// per-pin vote: a level counts once stages two and three agree, else it holds
	for (genvar g = 0; g < `NMSC_PIN_W; g++) begin : g_vote
		assign lvl_vote[g] = (r_reg.sync2[g] == r_reg.sync3[g]) ?
			r_reg.sync3[g] : r_reg.lvl[g];
	end

	// next-state logic
	always_comb begin
		r_next = r_reg;
		r_next.update = 1'b0;
		r_next.sw_reset = 1'b0;

		// three-stage pin filter; stage one feeds stage two only
		r_next.sync1 = pins;
		r_next.sync2 = r_reg.sync1;
		r_next.sync3 = r_reg.sync2;
		r_next.lvl = lvl_vote;

		// decode on the filtered write strobe rising edge
		wr_rise = r_next.lvl[`NMSC_PIN_WR] & ~r_reg.lvl[`NMSC_PIN_WR]; // [RL1]
		rd_idle = r_next.lvl[`NMSC_PIN_RD]; // [RL1]
		dc_sel = r_next.lvl[`NMSC_PIN_DC];
		ext_on = r_next.lvl[`NMSC_PIN_EXT];
		rx_byte = r_next.lvl[7:0];

		// parameter fields; upper data lines never reach this point
		par15 = rx_byte[`NMSC_B15_LSB +: 3]; // [RL3]
		par23 = rx_byte[`NMSC_B23_LSB +: 3]; // [RL3]

		// a write with read strobe low is a bus fault and is dropped
		if (wr_rise && rd_idle) begin
			if (!dc_sel) begin
				// command byte: any other code cancels a pending parameter
				unique case (rx_byte)
					`NMSC_CMD_BOOST_NORMAL: begin
						// no power or display state gates this, only the pin
						if (ext_on) begin // [RL6] [RL7]
							r_next.state = nmsc_pkg::NMSC_DEV_PARAM; // [RL1]
						end else begin
							r_next.state = nmsc_pkg::NMSC_DEV_CMD; // [RL9]
						end
					end
					`NMSC_CMD_SW_RESET: begin
						r_next.state = nmsc_pkg::NMSC_DEV_CMD;
						r_next.b15 = `NMSC_B15_RST; // [RL8]
						r_next.b23 = `NMSC_B23_RST; // [RL8]
						r_next.sw_reset = 1'b1;
					end
					default: begin
						r_next.state = nmsc_pkg::NMSC_DEV_CMD;
					end
				endcase
			end else begin
				// parameter byte; only the first one after the command counts
				unique case (r_reg.state)
					nmsc_pkg::NMSC_DEV_PARAM: begin
						if (ext_on) begin // [RL6]
							r_next.b15 = par15; // [RL2] [RL3]
							r_next.b23 = par23; // [RL2] [RL3]
							r_next.update = 1'b1;
						end
						// pin dropped between command and parameter: keep old fields
						r_next.state = nmsc_pkg::NMSC_DEV_CMD; // [RL9]
					end
					nmsc_pkg::NMSC_DEV_CMD: begin
						r_next.state = nmsc_pkg::NMSC_DEV_CMD;
					end
					default: begin
						// illegal state code: fall back to waiting for a command
						r_next.state = nmsc_pkg::NMSC_DEV_CMD;
					end
				endcase
			end
		end

		// period decode follows the stored codes; inhibited codes are flagged, not fixed up
		r_next.b15_16ths = cyc15(r_next.b15); // [RL4]
		r_next.b23_16ths = cyc23(r_next.b23); // [RL5]
		r_next.b23_inhibit = inh23(r_next.b23); // [RL5]
	end

	// state register with synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= RST; // [RL8]
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state register
	assign booster15_cycle_sel = r_reg.b15; // [RL3]
	assign booster23_cycle_sel = r_reg.b23; // [RL3]

	// decoded periods and the inhibit flag
	assign booster15_cycle_16ths = r_reg.b15_16ths;
	assign booster23_cycle_16ths = r_reg.b23_16ths;
	assign booster23_inhibit = r_reg.b23_inhibit;

	// one-cycle pulses
	assign cycle_update = r_reg.update;
	assign sw_reset_seen = r_reg.sw_reset;

endmodule : nmsc_device

// [verif/nmsc_chk_assertions.sv]
// wire checks on the host-to-driver pins
`timescale 1ns/1ps
`include "nmsc_params.svh"
module nmsc_chk (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic data_cmd_select, // 0 command, 1 parameter
	input wire logic read_strobe_n, // read strobe
	input wire logic write_strobe_n, // write strobe
	input wire logic [`NMSC_BUS_W-1:0] data_bus, // data lines
	input wire logic ext_cmd_enable_pin // extension enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// the host only ever writes
	property p_rd_idle;
		read_strobe_n;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read strobe low");
	property p_cmd_code;
		$rose(write_strobe_n) && !data_cmd_select |-> data_bus[7:0] inside {8'hc2, 8'h01};
	endproperty
	a_cmd_code: assert property (p_cmd_code) else $error("bad command byte");
	property p_par_bits;
		$rose(write_strobe_n) && data_cmd_select |-> data_bus[7] && !data_bus[3];
	endproperty
	a_par_bits: assert property (p_par_bits) else $error("bad parameter marks");
	property p_b23_ok;
		$rose(write_strobe_n) && data_cmd_select |-> data_bus[6:4] inside {[3'h1:3'h4]};
	endproperty
	a_b23_ok: assert property (p_b23_ok) else $error("inhibited code sent");
	property p_ext_on;
		$rose(write_strobe_n) |-> ext_cmd_enable_pin;
	endproperty
	a_ext_on: assert property (p_ext_on) else $error("strobe with pin low");
	property p_low_len;
		$fell(write_strobe_n) |-> (!write_strobe_n)[*4] ##1 write_strobe_n;
	endproperty
	a_low_len: assert property (p_low_len) else $error("strobe width");
	property p_par_next;
		$rose(write_strobe_n) && !data_cmd_select && data_bus[7:0] == 8'hc2
			|-> ##[1:8] ($fell(write_strobe_n) && data_cmd_select);
	endproperty
	a_par_next: assert property (p_par_next) else $error("parameter missing");
	property p_hold;
		!write_strobe_n && !$past(write_strobe_n) |-> $stable(data_bus) && $stable(data_cmd_select);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved in strobe");
endmodule : nmsc_chk

// [verif/tb.sv]
// self-checking bench: axi host, pin link, two driver decoders
`timescale 1ns/1ps
`include "nmsc_params.svh"
module tb;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic awready, wready, bvalid, arready, rvalid, upd, swr, inh, inh2;
	logic [1:0] bresp, rresp, resp;
	logic [2:0] s15, s23, t15, t23;
	logic [7:0] c15, c23, u15, u23;
	logic [16:0] lf = 17'h12f9e;
	int err_count = 0, check_count = 0, cyc = 0, m15 = 2, m23 = 3, k;
	nmsc_if link_if ();
	nmsc_if bad_if ();
	nmsc_host nmsc_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_if));
	nmsc_device nmsc_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if),
		.booster15_cycle_sel(s15), .booster23_cycle_sel(s23), .booster15_cycle_16ths(c15),
		.booster23_cycle_16ths(c23), .booster23_inhibit(inh), .cycle_update(upd),
		.sw_reset_seen(swr));
	// second decoder faces a bench driver that breaks the host rules
	nmsc_device nmsc_device_inst2 (.aclk(aclk), .aresetn(aresetn), .link(bad_if),
		.booster15_cycle_sel(t15), .booster23_cycle_sel(t23), .booster15_cycle_16ths(u15),
		.booster23_cycle_16ths(u23), .booster23_inhibit(inh2), .cycle_update(),
		.sw_reset_seen());
	nmsc_chk nmsc_chk_inst (.aclk(aclk), .aresetn(aresetn),
		.data_cmd_select(link_if.data_cmd_select), .read_strobe_n(link_if.read_strobe_n),
		.write_strobe_n(link_if.write_strobe_n), .data_bus(link_if.data_bus),
		.ext_cmd_enable_pin(link_if.ext_cmd_enable_pin));
	initial forever #4 aclk = ~aclk;
	// idle pins on the rule-breaking link
	initial begin
		bad_if.write_strobe_n <= 1'h1;
		bad_if.read_strobe_n <= 1'h1;
		bad_if.data_cmd_select <= 1'h0;
		bad_if.data_bus <= 18'h0;
		bad_if.ext_cmd_enable_pin <= 1'h0;
	end
	// cycle ceiling so a hung handshake still ends the run
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction : lfsr_next
	task automatic tally_and_finish();
		if (err_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic chk_fld(input int e15, input int e23, input logic [2:0] a,
		input logic [2:0] b, input logic [7:0] ca, input logic [7:0] cb, input logic ih);
		chk("sel15", e15, a);
		chk("sel23", e23, b);
		chk("cyc15", 1 << e15, ca);
		chk("cyc23", (e23 inside {[1:4]}) ? 1 << e23 : 0, cb);
		chk("inh23", !(e23 inside {[1:4]}), ih);
	endtask : chk_fld
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready === 1'h1) awvalid <= 1'h0;
			if (wvalid && wready === 1'h1) wvalid <= 1'h0;
			if (bvalid === 1'h1) begin
				resp = bresp;
				bready <= 1'h0;
				break;
			end
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready === 1'h1) arvalid <= 1'h0;
			if (rvalid === 1'h1) begin
				rd = rdata;
				resp = rresp;
				rready <= 1'h0;
				break;
			end
		end
	endtask : axi_rd
	task automatic send(input logic [2:0] a, input logic [2:0] b, input logic ok);
		axi_wr(`NMSC_REG_SEND, {25'h0, b, 1'h0, a});
		chk("bresp", `NMSC_RESP_OKAY, resp);
		if (ok) begin
			m15 = a;
			m23 = b;
			for (k = 0; upd !== 1'h1 && k < 60; k++) @(posedge aclk);
			chk("upd", 1'h1, upd);
			axi_rd(`NMSC_REG_STATUS);
			chk("status", 32'h0, rd);
		end else repeat (30) @(posedge aclk);
		chk_fld(m15, m23, s15, s23, c15, c23, inh);
	endtask : send
	task automatic pin_byte(input logic dc, input logic [7:0] d, input logic ext);
		@(posedge aclk);
		lf = lfsr_next(lf);
		bad_if.data_cmd_select <= dc;
		bad_if.data_bus <= {lf[9:0], d}; // upper lines carry noise
		bad_if.ext_cmd_enable_pin <= ext;
		bad_if.write_strobe_n <= 1'h0;
		repeat (4) @(posedge aclk);
		bad_if.write_strobe_n <= 1'h1;
		repeat (8) @(posedge aclk);
	endtask : pin_byte
	// main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		chk_fld(2, 3, s15, s23, c15, c23, inh);
		axi_rd(`NMSC_REG_CFG);
		chk("cfg", 32'h0, rd);
		axi_wr(`NMSC_REG_CFG, 32'h1);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr_next(lf);
			send(3'(i), lf[1:0] + 3'h1, 1'h1);
		end
		send(3'h1, 3'h6, 1'h0);
		axi_rd(`NMSC_REG_STATUS);
		chk("status", 32'h2, rd);
		axi_wr(`NMSC_REG_STATUS, 32'h2);
		axi_wr(`NMSC_REG_CFG, 32'h0);
		send(3'h7, 3'h1, 1'h0);
		axi_rd(`NMSC_REG_STATUS);
		chk("status", 32'h4, rd);
		axi_wr(`NMSC_REG_STATUS, 32'h4);
		axi_wr(`NMSC_REG_CFG, 32'h1);
		axi_wr(`NMSC_REG_SWRST, 32'h0);
		for (k = 0; swr !== 1'h1 && k < 60; k++) @(posedge aclk);
		chk("swr", 1'h1, swr);
		m15 = 2;
		m23 = 3;
		chk_fld(m15, m23, s15, s23, c15, c23, inh);
		axi_wr(8'h10, 32'h1);
		chk("bresp", `NMSC_RESP_SLVERR, resp);
		axi_rd(8'h10);
		chk("rresp", `NMSC_RESP_SLVERR, resp);
		pin_byte(1'h0, 8'hc2, 1'h0);
		pin_byte(1'h1, 8'hd5, 1'h1);
		chk_fld(2, 3, t15, t23, u15, u23, inh2);
		pin_byte(1'h0, 8'hc2, 1'h1);
		pin_byte(1'h1, 8'hd5, 1'h0);
		chk_fld(2, 3, t15, t23, u15, u23, inh2);
		pin_byte(1'h0, 8'hc2, 1'h1);
		pin_byte(1'h1, 8'he7, 1'h1);
		chk_fld(7, 6, t15, t23, u15, u23, inh2);
		pin_byte(1'h1, 8'h90, 1'h1);
		chk_fld(7, 6, t15, t23, u15, u23, inh2);
		pin_byte(1'h0, 8'h01, 1'h1);
		chk_fld(2, 3, t15, t23, u15, u23, inh2);
		send(3'h0, 3'h4, 1'h1);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		chk_fld(2, 3, s15, s23, c15, c23, inh);
		chk("upd", 1'h0, upd);
		axi_rd(`NMSC_REG_CFG);
		chk("cfg", 32'h0, rd);
		tally_and_finish();
	end
endmodule : tb
